//--- bench/pmom_ovl_mem.sv
`timescale 1ns/1ns
`default_nettype none
module pmom_ovl_mem (
  // bus side
  input  wire logic                         clk,
  input  wire logic                         ext_sel,
  input  wire logic [pmom_pkg::PMOM_AW-1:0] ext_addr,
  // what the overlay memory saw
  output logic [pmom_pkg::PMOM_AW-1:0]      last_addr,
  output int                                hits
);
  initial begin
    last_addr = 14'h0;
    hits = 0;
  end
  // a13 picks the bank, so the full address is kept
  always @(posedge clk) begin
    if (ext_sel === 1'h1) begin
      last_addr <= ext_addr;
      hits <= hits + 1;
    end
  end
endmodule
`default_nettype wire

//--- bench/pmom_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pmom_top_sva #(
  parameter int AW = 14
) (
  // clock and resets
  input wire logic                          REF_CLK,
  input wire logic                          RST_B,
  input wire logic                          EMU_RST_B,
  // straps
  input wire logic                          MAP_MODE_PIN,
  input wire logic                          BOOT_CFG_PIN,
  input wire logic                          BUS_REQ_PIN,
  input wire logic                          HOST_MODE_PIN,
  // boot and map
  input wire logic                          BOOT_ACTIVE,
  input wire logic                          FETCH_START,
  input wire logic [AW-1:0]                 FETCH_ADDR,
  input wire logic                          PM_REQ,
  input wire logic [AW-1:0]                 PM_ADDR,
  input wire logic                          PMD_REQ,
  input wire logic [AW-1:0]                 PMD_ADDR,
  input wire logic                          INT_SEL_INSTR,
  input wire logic                          EXT_SEL,
  input wire logic [AW-1:0]                 EXT_ADDR,
  input wire logic                          RESV_ERR,
  input wire logic                          OVL_ERR,
  // clocks and mask
  input wire logic                          CYCLE_CLOCK_OUTPUT,
  input wire logic                          IN_CLK_TICK,
  input wire logic [pmom_pkg::PMOM_IRQ_N-1:0] IRQ_MASK
);
  import pmom_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!(RST_B && EMU_RST_B));
  a_tick_alt: assert property (IN_CLK_TICK |=> !IN_CLK_TICK)
    else $error("input clock marker did not alternate");
  a_cycle_clock_output_alt: assert property (CYCLE_CLOCK_OUTPUT |=> !CYCLE_CLOCK_OUTPUT)
    else $error("cycle clock output stuck high");
  a_fetch_zero: assert property (FETCH_START |-> FETCH_ADDR == '0 ##1 !FETCH_START)
    else $error("first fetch not a one cycle pulse at zero");
  a_boot_quiet: assert property (BOOT_ACTIVE |-> !FETCH_START)
    else $error("fetch started during boot");
  a_boot_cause: assert property ($rose(BOOT_ACTIVE) |-> BOOT_CFG_PIN && !BUS_REQ_PIN && !MAP_MODE_PIN)
    else $error("boot started without its conditions");
  a_ovl_addr: assert property (EXT_SEL && !MAP_MODE_PIN && !HOST_MODE_PIN && $past(PM_REQ && PM_ADDR[13]) |-> EXT_ADDR[12:0] == $past(PM_ADDR[12:0]))
    else $error("overlay low address bits wrong");
  a_host_a0: assert property (EXT_SEL && HOST_MODE_PIN |-> EXT_ADDR[13:1] == '0)
    else $error("host mode drove more than one address line");
  a_map_lower: assert property (EXT_SEL && MAP_MODE_PIN |-> !EXT_ADDR[13])
    else $error("map high external access outside lower half");
  a_no_int_map: assert property (MAP_MODE_PIN |-> !INT_SEL_INSTR)
    else $error("internal hit with map pin high");
  a_err_cause: assert property (RESV_ERR || OVL_ERR |-> $past(PM_REQ && PM_ADDR[13] || PMD_REQ && PMD_ADDR[13]))
    else $error("fault flag without upper half access");
  a_err_mode: assert property (RESV_ERR |-> MAP_MODE_PIN && !OVL_ERR)
    else $error("reserved flag in wrong map mode");
  // async reset: checked while reset is low
  a_reset_mask: assert property (@(posedge REF_CLK) disable iff (1'b0) !(RST_B && EMU_RST_B) |-> IRQ_MASK == '0 && !BOOT_ACTIVE)
    else $error("mask not cleared in reset");
  c_boot: cover property ($rose(BOOT_ACTIVE));
  c_ext: cover property (EXT_SEL && EXT_ADDR[13]);
  c_resv: cover property (RESV_ERR);
endmodule
bind pmom_top pmom_top_sva #(.AW(AW)) chk_u (
  .REF_CLK, .RST_B, .EMU_RST_B, .MAP_MODE_PIN, .BOOT_CFG_PIN, .BUS_REQ_PIN,
  .HOST_MODE_PIN, .BOOT_ACTIVE, .FETCH_START, .FETCH_ADDR, .PM_REQ, .PM_ADDR,
  .PMD_REQ, .PMD_ADDR, .INT_SEL_INSTR, .EXT_SEL, .EXT_ADDR, .RESV_ERR,
  .OVL_ERR, .CYCLE_CLOCK_OUTPUT, .IN_CLK_TICK, .IRQ_MASK
);
`default_nettype wire

//--- bench/pmom_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pmom_top_tb;
  import pmom_pkg::*;
  logic        clk = 1'h0, rst_b = 1'h1, emu_b = 1'h1, map_p = 1'h0;
  logic        cfg_p = 1'h1;
  logic        breq = 1'h0, host_p = 1'h0, bdone = 1'h0, pm_req = 1'h0;
  logic        pd_req = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [13:0] pm_a = 14'h0, pd_a = 14'h0, fad, exa, mem_a, a;
  logic [7:0]  pad = 8'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        bact, fst, int_i, int_d, ext, stall, resv, oerr, cko, tick;
  logic        six, prdy, perr, err, seen, prev;
  logic [10:0] mask, mk;
  logic [1:0]  o;
  logic [16:0] e;
  int          mem_hits, mismatches, checks, seed, n, i;
  always #50 clk = ~clk;
  pmom_top dut_u (
    .REF_CLK(clk), .RST_B(rst_b), .EMU_RST_B(emu_b), .MAP_MODE_PIN(map_p),
    .BOOT_CFG_PIN(cfg_p), .BUS_REQ_PIN(breq), .HOST_MODE_PIN(host_p),
    .BOOT_DONE(bdone), .BOOT_ACTIVE(bact), .FETCH_START(fst),
    .FETCH_ADDR(fad), .PM_REQ(pm_req), .PM_ADDR(pm_a), .PMD_REQ(pd_req),
    .PMD_ADDR(pd_a), .INT_SEL_INSTR(int_i), .INT_SEL_DATA(int_d),
    .EXT_SEL(ext), .EXT_ADDR(exa), .PM_STALL(stall), .RESV_ERR(resv),
    .OVL_ERR(oerr), .CYCLE_CLOCK_OUTPUT(cko), .IN_CLK_TICK(tick),
    .SIX_IRQ_MODE(six), .IRQ_MASK(mask), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pad), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr)
  );
  pmom_ovl_mem mem_u (.clk(clk), .ext_sel(ext), .ext_addr(exa),
    .last_addr(mem_a), .hits(mem_hits));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // {int, ext, ovl fault, a13, a12:0}
  function automatic logic [16:0] exp_map(input logic [1:0] ov,
                                          input logic [13:0] ad);
    return {!ad[13], ad[13] && ov != 2'h0, ad[13] && ov == 2'h0,
            ov == 2'h2, ad[12:0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pad <= ad;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (prdy === 1'h1) break;
    end
    if (n == 20) begin
      mismatches++;
      complete_run();
    end
    rd = prd;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic acc(input logic [13:0] x, input logic dual);
    @(posedge clk);
    pm_req <= 1'h1;
    pm_a <= x;
    pd_req <= dual;
    pd_a <= {1'h0, x[12:0] ^ 13'h1555};
    @(posedge clk);
    pm_req <= 1'h0;
    pd_req <= 1'h0;
    @(negedge clk);
  endtask
  task automatic boot_seq(input logic m, cf, br, h, em);
    @(posedge clk);
    if (em) emu_b <= 1'h0;
    else rst_b <= 1'h0;
    map_p <= m;
    cfg_p <= cf;
    breq <= br;
    host_p <= h;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    emu_b <= 1'h1;
    seen = 1'h0;
    // loader answers as soon as boot shows
    for (n = 0; n < 60 && fst !== 1'h1; n++) begin
      @(posedge clk);
      seen = seen | (bact === 1'h1);
      bdone <= (bact === 1'h1);
    end
    if (n == 60) begin
      mismatches++;
      complete_run();
    end
    chk_flag(seen, cf & !br & !m);
    chk_word({18'h0, fad}, 32'h0);
    apb(1'h0, PMOM_OFF_MASK, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'h0, PMOM_OFF_MODE_STATUS_REGISTER, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'h0, PMOM_OFF_STAT, 32'h0);
    chk_word(rd & 32'h1b, {27'h0, 2'h3, 1'h0, h, m});
    $display("reset test done map %0d boot %0d", m, seen);
  endtask
  initial begin
    // assert after every process waits, so the async reset edge is seen
    rst_b <= 1'h0;
    seed = 70054;
    mismatches = 0;
    checks = 0;
    repeat (PMOM_PLL_LOCK_CYC) @(posedge clk);
    boot_seq(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    apb(1'h0, 8'h3c, 32'h0);
    chk_flag(err, 1'h1);
    apb(1'h1, PMOM_OFF_SIZE, 32'h1);
    chk_flag(err, 1'h1);
    apb(1'h1, PMOM_OFF_OVL, 32'h3);
    chk_flag(err, 1'h1);
    mk = 11'($random(seed)) | 11'h1;
    apb(1'h1, PMOM_OFF_MASK, {21'h0, mk});
    apb(1'h1, PMOM_OFF_CTRL, 32'h3);
    repeat (2) @(negedge clk);
    chk_word({21'h0, mask}, {21'h0, mk});
    chk_flag(six, 1'h1);
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      chk_flag(cko, 1'h0);
    end
    apb(1'h1, PMOM_OFF_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    prev = cko;
    @(negedge clk);
    chk_flag(cko, !prev);
    chk_flag(six, 1'h0);
    prev = tick;
    @(negedge clk);
    chk_flag(tick, !prev);
    $display("config test done");
    // first four are the half boundaries
    for (i = 0; i < 40; i++) begin
      o = 2'($unsigned($random(seed)) % 3);
      a = (i < 4) ? {i[0], {13{i[1]}}} : 14'($random(seed));
      apb(1'h1, PMOM_OFF_OVL, {30'h0, o});
      acc(a, 1'h1);
      e = exp_map(o, a);
      chk_word({int_i, ext, oerr}, e[16:14]);
      chk_word({int_d, stall}, 2'h2);
      if (e[15]) chk_word(exa, e[13:0]);
      @(negedge clk);
      if (e[15]) chk_word(mem_a, e[13:0]);
    end
    chk_flag(mem_hits > 0, 1'h1);
    // overlay-0 upper access leaves a sticky flag, cleared by writing one
    apb(1'h1, PMOM_OFF_OVL, 32'h0);
    acc(14'h2000, 1'h0);
    apb(1'h0, PMOM_OFF_STAT, 32'h0);
    chk_word(rd & 32'h60, 32'h40);
    apb(1'h1, PMOM_OFF_STAT, 32'h40);
    apb(1'h0, PMOM_OFF_STAT, 32'h0);
    chk_word(rd & 32'h40, 32'h0);
    $display("overlay test done");
    boot_seq(1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    boot_seq(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    apb(1'h1, PMOM_OFF_OVL, 32'h1);
    chk_flag(err, 1'h1);
    acc(14'h0100, 1'h1);
    chk_word({int_i, ext, exa}, {2'h1, 14'h0100});
    chk_word({int_d, stall}, 2'h1);
    acc(14'h2100, 1'h0);
    chk_word({resv, ext}, 2'h2);
    boot_seq(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    acc(14'h0123, 1'h0);
    chk_word({ext, exa}, {1'h1, 14'h0001});
    $display("map mode test done");
    complete_run();
  end
endmodule
`default_nettype wire

//--- verilog/pmom_map.sv
`timescale 1ns/1ns
`default_nettype none
module pmom_map (
  // decode port
  pmom_map_if.map m
);
  import pmom_pkg::*;
  wire upper   = m.addr[PMOM_UPPER_BIT];
  wire ovl_on  = (m.ovl != PMOM_OVL_INT);
  wire ext_ovl = !m.map_mode && upper && ovl_on;
  wire ext_low = m.map_mode && !upper;
  wire a13     = (m.ovl == PMOM_OVL_2);
  wire [PMOM_AW-1:0] ovl_addr =
    {a13, m.addr[PMOM_UPPER_BIT-1:0]};
  wire [PMOM_AW-1:0] host_addr =
    {{(PMOM_AW-1){1'b0}}, m.addr[0]};
  assign m.int_sel = m.req && !m.map_mode && !upper;
  assign m.ext_sel = m.req && (ext_ovl || ext_low);
  assign m.resv    = m.req && m.map_mode && upper;
  assign m.illegal = m.req && !m.map_mode && upper
                     && !ovl_on;
  assign m.ext_addr = m.host_mode ? host_addr :
                      ext_ovl ? ovl_addr : m.addr;
endmodule
`default_nettype wire

//--- verilog/pmom_map_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pmom_map_if;
  import pmom_pkg::*;
  logic [PMOM_AW-1:0]    addr;
  logic                  req;
  logic [PMOM_OVL_W-1:0] ovl;
  logic                  map_mode;
  logic                  host_mode;
  logic                  int_sel;
  logic                  ext_sel;
  logic                  resv;
  logic                  illegal;
  logic [PMOM_AW-1:0]    ext_addr;
  modport map (input addr, req, ovl, map_mode, host_mode,
               output int_sel, ext_sel, resv, illegal, ext_addr);
  modport user (output addr, req, ovl, map_mode, host_mode,
                input int_sel, ext_sel, resv, illegal, ext_addr);
endinterface
`default_nettype wire

//--- verilog/pmom_pkg.sv
// Summary of operation
// - processor cycle runs at twice the input clock rate; timing derives from it
// - cycle clock output toggles each processor cycle unless disable bit set
// - reset after power-up keeps clocks running, no stabilisation wait; here CYCLE_CLOCK_OUTPUT and IN_CLK_TICK are held low during reset
// - master reset empties stacks, masks all interrupts, clears mode status
// - boot runs at release only with no bus request and boot configured
// - after boot the first fetch comes from program address zero
// - emulator reset acts exactly like the master reset
// - host memory mode drives only address line A0 externally
// - configuration picks four irqs with two ports or six with one
// - internal program RAM serves opcode and data read in one cycle
// - map pin low: overlay zero internal 8K, nonzero sends upper half out; here an overlay-zero upper access is flagged illegal instead
// - overlay 1 drives A13 low, overlay 2 high, low 13 bits passed
// - sequencer ignores overlay select; changing it inside loops breaks them
// - overlay select is not saved on the mode stack at interrupts
// - map pin high: no boot, overlay forced zero, lower half external
// - data memory holds 8160 user words and 32 mapped registers
// - byte memory address is 22 bits, reached via the byte dma port
// - i/o space holds 2048 sixteen-bit locations
package pmom_pkg;
  localparam int PMOM_AW      = 14;
  localparam int PMOM_OVL_W   = 2;
  localparam int PMOM_IRQ_N   = 11;
  localparam int PMOM_MODE_STATUS_REGISTER_W = 7;
  localparam int PMOM_PA_W    = 8;
  // register byte offsets
  localparam logic [7:0] PMOM_OFF_CTRL  = 8'h00;
  localparam logic [7:0] PMOM_OFF_OVL   = 8'h04;
  localparam logic [7:0] PMOM_OFF_MODE_STATUS_REGISTER = 8'h08;
  localparam logic [7:0] PMOM_OFF_MASK  = 8'h0c;
  localparam logic [7:0] PMOM_OFF_STAT  = 8'h10;
  localparam logic [7:0] PMOM_OFF_SIZE  = 8'h14;
  // control bits
  localparam int PMOM_CTRL_CLOCK_OUTPUT_DISABLE = 0;
  localparam int PMOM_CTRL_SIXIRQ  = 1;
  // status bits
  localparam int PMOM_ST_MAP    = 0;
  localparam int PMOM_ST_HOST   = 1;
  localparam int PMOM_ST_BOOT   = 2;
  localparam int PMOM_ST_RUN    = 3;
  localparam int PMOM_ST_SPEMPT = 4;
  localparam int PMOM_ST_RESV   = 5;
  localparam int PMOM_ST_ILL    = 6;
  // overlay codes and address fields
  localparam logic [1:0] PMOM_OVL_INT = 2'h0;
  localparam logic [1:0] PMOM_OVL_1   = 2'h1;
  localparam logic [1:0] PMOM_OVL_2   = 2'h2;
  localparam int PMOM_UPPER_BIT = 13;
  localparam logic [PMOM_AW-1:0] PMOM_BOOT_VEC = 14'h0000;
  // memory space sizes
  localparam logic [15:0] PMOM_DM_USER  = 16'h1fe0;
  localparam logic [5:0]  PMOM_DM_REGS  = 6'h20;
  localparam logic [4:0]  PMOM_BYTE_AW  = 5'h16;
  localparam logic [11:0] PMOM_IO_LOCS  = 12'h800;
  // timing
  localparam int PMOM_CLK_HZ       = 10_000_000;
  localparam int PMOM_CYC_PER_IN   = 2;
  localparam int PMOM_PLL_LOCK_IN  = 2000;
  localparam int PMOM_PLL_LOCK_CYC = PMOM_PLL_LOCK_IN * PMOM_CYC_PER_IN;
  localparam int PMOM_SYNC_WAIT    = 2;
  localparam logic [31:0] PMOM_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    PMOM_S_CAPT, PMOM_S_BOOT, PMOM_S_FETCH, PMOM_S_RUN
  } pmom_state_t;
endpackage

//--- verilog/pmom_top.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pmom_top #(
  parameter int AW = pmom_pkg::PMOM_AW
) (
  // clock and resets
  input  wire logic                      REF_CLK,
  input  wire logic                      RST_B,
  input  wire logic                      EMU_RST_B,
  // strap and system pins
  input  wire logic                      MAP_MODE_PIN,
  input  wire logic                      BOOT_CFG_PIN,
  input  wire logic                      BUS_REQ_PIN,
  input  wire logic                      HOST_MODE_PIN,
  // boot loader handshake
  input  wire logic                      BOOT_DONE,
  output logic                           BOOT_ACTIVE,
  output logic                           FETCH_START,
  output logic [AW-1:0]                  FETCH_ADDR,
  // program memory accesses, opcode and data
  input  wire logic                      PM_REQ,
  input  wire logic [AW-1:0]             PM_ADDR,
  input  wire logic                      PMD_REQ,
  input  wire logic [AW-1:0]             PMD_ADDR,
  output logic                           INT_SEL_INSTR,
  output logic                           INT_SEL_DATA,
  output logic                           EXT_SEL,
  output logic [AW-1:0]                  EXT_ADDR,
  output logic                           PM_STALL,
  output logic                           RESV_ERR,
  output logic                           OVL_ERR,
  // clocks out and configuration
  output logic                           CYCLE_CLOCK_OUTPUT,
  output logic                           IN_CLK_TICK,
  output logic                           SIX_IRQ_MODE,
  output logic [pmom_pkg::PMOM_IRQ_N-1:0] IRQ_MASK,
  // apb slave
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [pmom_pkg::PMOM_PA_W-1:0] PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic [31:0]                    PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR
);
  import pmom_pkg::*;

  if (AW != PMOM_AW) begin : g_bad_aw
    $error("address width must match the program space");
  end

  // both resets merged; either one starts the master reset
  wire rst_n_in = RST_B && EMU_RST_B;

  logic rs1_r;
  logic rs2_r;
  always_ff @(posedge REF_CLK or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  wire rst_n = rs2_r;

  // pin synchronisers; straps are read only after two stages
  localparam int NPIN = 4;
  localparam int P_MAP  = 0;
  localparam int P_BOOT = 1;
  localparam int P_BREQ = 2;
  localparam int P_HOST = 3;
  wire [NPIN-1:0] pins_in =
    {HOST_MODE_PIN, BUS_REQ_PIN, BOOT_CFG_PIN, MAP_MODE_PIN};
  logic [NPIN-1:0] sy1_r;
  logic [NPIN-1:0] sy2_r;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= pins_in;
      sy2_r <= sy1_r;
    end
  end

  // input clock rate as an enable; this clock is the processor cycle
  logic in_tick_r;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) in_tick_r <= 1'b0;
    else        in_tick_r <= !in_tick_r;
  end

  // apb handshake: one wait state, data and error registered
  wire apb_acc  = PSEL && PENABLE;
  wire apb_take = apb_acc && !PREADY;
  wire apb_done = apb_acc && PREADY;
  wire wr_en    = apb_done && PWRITE;
  wire sel_ctrl  = (PADDR == PMOM_OFF_CTRL);
  wire sel_ovl   = (PADDR == PMOM_OFF_OVL);
  wire sel_mode_status_register = (PADDR == PMOM_OFF_MODE_STATUS_REGISTER);
  wire sel_mask  = (PADDR == PMOM_OFF_MASK);
  wire sel_stat  = (PADDR == PMOM_OFF_STAT);
  wire sel_size  = (PADDR == PMOM_OFF_SIZE);
  wire mapped = sel_ctrl || sel_ovl || sel_mode_status_register ||
                sel_mask || sel_stat || sel_size;

  // registers
  logic [1:0]              ctrl_r;
  logic [PMOM_OVL_W-1:0]   ovl_r;
  logic [PMOM_MODE_STATUS_REGISTER_W-1:0] mode_status_register_r;
  logic [PMOM_IRQ_N-1:0]   mask_r;
  logic                    map_r;
  logic                    host_r;
  logic                    resv_st_r;
  logic                    ill_st_r;
  pmom_state_t             st_r;
  pmom_state_t             st_nxt;
  logic [1:0]              wait_r;

  // overlay accepts only the two overlay codes or zero, and zero alone
  // when the map pin was high
  wire [PMOM_OVL_W-1:0] ovl_wd = PWDATA[PMOM_OVL_W-1:0];
  wire ovl_ok = (ovl_wd == PMOM_OVL_INT) ||
                (!map_r && (ovl_wd == PMOM_OVL_1 ||
                            ovl_wd == PMOM_OVL_2));
  wire bad_wr = PWRITE && ((sel_ovl && !ovl_ok) ||
                           sel_stat && 1'b0 || sel_size);
  wire err_nxt = !mapped || bad_wr;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) ctrl_r <= 2'h0;
    else if (wr_en && sel_ctrl) ctrl_r <= PWDATA[1:0];
  end

  // overlay select lives outside the mode stack; interrupt code saves it
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) ovl_r <= PMOM_OVL_INT;
    else if (wr_en && sel_ovl && ovl_ok) ovl_r <= ovl_wd;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) mode_status_register_r <= '0;
    else if (wr_en && sel_mode_status_register)
      mode_status_register_r <= PWDATA[PMOM_MODE_STATUS_REGISTER_W-1:0];
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) mask_r <= '0;
    else if (wr_en && sel_mask)
      mask_r <= PWDATA[PMOM_IRQ_N-1:0];
  end

  // strap capture, held until the next reset
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      map_r  <= 1'b0;
      host_r <= 1'b0;
    end else if (st_r == PMOM_S_CAPT && wait_r == 2'(PMOM_SYNC_WAIT)) begin
      map_r  <= sy2_r[P_MAP];
      host_r <= sy2_r[P_HOST];
    end
  end

  // boot decision and first fetch
  wire cap_done = (wait_r == 2'(PMOM_SYNC_WAIT));
  wire boot_go  = sy2_r[P_BOOT] && !sy2_r[P_BREQ] &&
                  !sy2_r[P_MAP];
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      PMOM_S_CAPT:
        if (cap_done) st_nxt = boot_go ? PMOM_S_BOOT : PMOM_S_FETCH;
      PMOM_S_BOOT:
        if (BOOT_DONE) st_nxt = PMOM_S_FETCH;
      PMOM_S_FETCH: st_nxt = PMOM_S_RUN;
      PMOM_S_RUN:   st_nxt = PMOM_S_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= PMOM_S_CAPT;
      wait_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      if (!cap_done) wait_r <= wait_r + 2'h1;
    end
  end

  // two decoders, one per read port of the dual-access program RAM
  pmom_map_if mif [2] ();
  wire [AW-1:0] a_in [2];
  wire          r_in [2];
  assign a_in[0] = PM_ADDR;
  assign a_in[1] = PMD_ADDR;
  assign r_in[0] = PM_REQ && (st_r == PMOM_S_RUN);
  assign r_in[1] = PMD_REQ && (st_r == PMOM_S_RUN);
  for (genvar g = 0; g < 2; g++) begin : g_port
    assign mif[g].addr      = a_in[g];
    assign mif[g].req       = r_in[g];
    assign mif[g].ovl       = ovl_r;
    assign mif[g].map_mode  = map_r;
    assign mif[g].host_mode = host_r;
    pmom_map u_map (.m(mif[g]));
  end

  // one external bus: opcode wins, data waits a cycle
  wire ext_i  = mif[0].ext_sel;
  wire ext_d  = mif[1].ext_sel;
  wire stall  = ext_i && ext_d;
  wire [AW-1:0] ext_a = ext_i ? mif[0].ext_addr : mif[1].ext_addr;
  wire resv_any = mif[0].resv || mif[1].resv;
  wire ill_any  = mif[0].illegal || mif[1].illegal;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      INT_SEL_INSTR <= 1'b0;
      INT_SEL_DATA  <= 1'b0;
      EXT_SEL       <= 1'b0;
      EXT_ADDR      <= '0;
      PM_STALL      <= 1'b0;
      RESV_ERR      <= 1'b0;
      OVL_ERR       <= 1'b0;
    end else begin
      INT_SEL_INSTR <= mif[0].int_sel;
      INT_SEL_DATA  <= mif[1].int_sel;
      EXT_SEL       <= ext_i || ext_d;
      EXT_ADDR      <= ext_a;
      PM_STALL      <= stall;
      RESV_ERR      <= resv_any;
      OVL_ERR       <= ill_any;
    end
  end

  // sticky access faults; a new fault beats a clear in the same cycle
  wire st_clr = wr_en && sel_stat;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      resv_st_r <= 1'b0;
      ill_st_r  <= 1'b0;
    end else begin
      resv_st_r <= resv_any ||
        (resv_st_r && !(st_clr && PWDATA[PMOM_ST_RESV]));
      ill_st_r  <= ill_any ||
        (ill_st_r && !(st_clr && PWDATA[PMOM_ST_ILL]));
    end
  end

  // read data
  wire [31:0] stat_v = {25'h0, ill_st_r, resv_st_r, 1'b1,
                        st_r == PMOM_S_RUN, st_r == PMOM_S_BOOT,
                        host_r, map_r};
  wire [31:0] size_v = {PMOM_DM_USER[12:0], PMOM_DM_REGS[5:0],
                        PMOM_BYTE_AW, PMOM_IO_LOCS[11:4]};
  wire [31:0] rd_v =
    sel_ctrl  ? {30'h0, ctrl_r} :
    sel_ovl   ? {30'h0, ovl_r} :
    sel_mode_status_register ? {25'h0, mode_status_register_r} :
    sel_mask  ? {21'h0, mask_r} :
    sel_stat  ? stat_v :
    sel_size  ? size_v : PMOM_ZERO;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PRDATA  <= PMOM_ZERO;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_take;
      PSLVERR <= apb_take && err_nxt;
      if (apb_take && !PWRITE) PRDATA <= rd_v;
    end
  end

  // pin-facing outputs
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CYCLE_CLOCK_OUTPUT <= 1'b0;
      IN_CLK_TICK        <= 1'b0;
      SIX_IRQ_MODE       <= 1'b0;
      IRQ_MASK           <= '0;
      BOOT_ACTIVE        <= 1'b0;
      FETCH_START        <= 1'b0;
      FETCH_ADDR         <= PMOM_BOOT_VEC;
    end else begin
      // held low while disabled to save pin power
      CYCLE_CLOCK_OUTPUT <= ctrl_r[PMOM_CTRL_CLOCK_OUTPUT_DISABLE] ? 1'b0 :
                            !CYCLE_CLOCK_OUTPUT;
      IN_CLK_TICK        <= in_tick_r;
      SIX_IRQ_MODE       <= ctrl_r[PMOM_CTRL_SIXIRQ];
      IRQ_MASK           <= mask_r;
      BOOT_ACTIVE        <= (st_nxt == PMOM_S_BOOT);
      FETCH_START        <= (st_nxt == PMOM_S_FETCH);
      FETCH_ADDR         <= PMOM_BOOT_VEC;
    end
  end

  // the sequencer sees plain addresses; overlay only steers the decoders
  // so loops must not span an overlay change
  wire unused_ok = &{1'b0, PMOM_PLL_LOCK_CYC[0]};
endmodule
`default_nettype wire
